// File: shared/hbpd_pkg.sv
package hbpd_pkg;
    // sizes
    localparam int NUM_HB = 3;   // half-bridges
    localparam int CODE_W = 6;   // gate current code width
    localparam int DLY_W = 6;    // delay code width
    localparam int ADDR_W = 3;   // register address width
    localparam int DATA_W = 32;  // register data width
    localparam int CNT_W = 4;    // regulation counter width
    localparam int TMR_W = 8;    // blanking timer width
    // timing, clock period and blanking windows in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int FW_BLANK_NS = 500;
    localparam int ACT_BLANK_NS = 500;
    localparam int FW_TIMEOUT_NS = 2000;
    // least times round up, the timeout (longest) rounds down
    localparam int FW_BLANK_CYC = (FW_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACT_BLANK_CYC = (ACT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FW_TIMEOUT_CYC = FW_TIMEOUT_NS / CLK_PERIOD_NS;
    // regulation thresholds
    localparam int MATCH_MIN = 8;
    localparam int ALT_MIN = 3;
    // gate current code range, 64 steps from 0.5 mA to 150 mA
    localparam int CUR_STEPS = 64;
    localparam int CUR_MIN_UA = 500;
    localparam int CUR_MAX_UA = 150000;
    localparam logic [CODE_W-1:0] CODE_LOWEST = 6'h00;
    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_TON = 3'h1;
    localparam logic [ADDR_W-1:0] REG_TOFF = 3'h2;
    localparam logic [ADDR_W-1:0] REG_CHG = 3'h3;
    localparam logic [ADDR_W-1:0] REG_PCHG = 3'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h5;
    // control field positions
    localparam int CNT_SEL_BIT = 0;
    localparam int DET_EN_BIT = 1;
    localparam int SCHEME_LSB = 2;
    localparam int POST_DIS_BIT = 4;
    localparam int PWM_EN_LSB = 5;
    localparam int DRIVE_LSB = 8;
    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
    localparam logic [NUM_HB*DLY_W-1:0] DLY_RST = 18'h00000;
    localparam logic [NUM_HB*CODE_W-1:0] CODE_RST = 18'h00000;
    // drive select encodings
    localparam logic [1:0] DRV_PASSIVE_OFF = 2'h0;
    localparam logic [1:0] DRV_LS_PWM = 2'h1;
    localparam logic [1:0] DRV_HS_PWM = 2'h2;
    localparam logic [1:0] DRV_ACTIVE_OFF = 2'h3;
    // per half-bridge sequencer state
    typedef enum logic [1:0] {SEQ_OFF, SEQ_HS, SEQ_LS} hbpd_seq_t;
    // gate command bundle of one half-bridge
    typedef struct packed {
        logic hs;        // high-side gate on
        logic ls;        // low-side gate on
        logic hold_off;  // both gates actively held off
        logic hard_off;  // discharge freewheel gate with hard current
    } hbpd_gate_t;
    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hbpd_bus_t;
endpackage

// File: hdl/hbpd_reg_track.sv
module hbpd_reg_track (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic strobe_in,
    input wire logic adaptive_in,
    input wire logic [hbpd_pkg::DLY_W-1:0] meas_on_in,
    input wire logic [hbpd_pkg::DLY_W-1:0] meas_off_in,
    input wire logic [hbpd_pkg::DLY_W-1:0] tgt_on_in,
    input wire logic [hbpd_pkg::DLY_W-1:0] tgt_off_in,
    output logic flag_out
);
    import hbpd_pkg::*;
    // all tracker state
    typedef struct packed {
        logic [CNT_W-1:0] on_cnt;   // turn-on match counter
        logic [CNT_W-1:0] off_cnt;  // turn-off match counter
        logic [1:0] on_alt;         // turn-on sign changes in a row
        logic [1:0] off_alt;        // turn-off sign changes in a row
        logic on_sign;              // last nonzero turn-on error above target
        logic off_sign;
        logic on_seen;              // a nonzero error has been seen
        logic off_seen;
        logic flag;
    } hbpd_trk_t;
    hbpd_trk_t s, next_s;

    // count one pwm cycle per strobe
    always_comb begin
        next_s = s;
        if (strobe_in) begin
            if (meas_on_in == tgt_on_in) begin
                if (s.on_cnt != '1) next_s.on_cnt = s.on_cnt + 1'b1;
            end else if (s.on_cnt != '0) begin
                next_s.on_cnt = s.on_cnt - 1'b1;
            end
            if (meas_off_in == tgt_off_in) begin
                if (s.off_cnt != '1) next_s.off_cnt = s.off_cnt + 1'b1;
            end else if (s.off_cnt != '0) begin
                next_s.off_cnt = s.off_cnt - 1'b1;
            end
            // sign changes of the turn-on error
            if (meas_on_in == tgt_on_in) begin
                next_s.on_alt = 2'h0;
            end else begin
                next_s.on_seen = 1'b1;
                next_s.on_sign = meas_on_in > tgt_on_in;
                if (s.on_seen && (s.on_sign != (meas_on_in > tgt_on_in))) begin
                    if (s.on_alt != 2'h3) next_s.on_alt = s.on_alt + 1'b1;
                end else begin
                    next_s.on_alt = 2'h0;
                end
            end
            // sign changes of the turn-off error
            if (meas_off_in == tgt_off_in) begin
                next_s.off_alt = 2'h0;
            end else begin
                next_s.off_seen = 1'b1;
                next_s.off_sign = meas_off_in > tgt_off_in;
                if (s.off_seen && (s.off_sign != (meas_off_in > tgt_off_in))) begin
                    if (s.off_alt != 2'h3) next_s.off_alt = s.off_alt + 1'b1;
                end else begin
                    next_s.off_alt = 2'h0;
                end
            end
        end
        // either condition; both counters at least eight
        // meaningful only under the adaptive scheme
        next_s.flag = adaptive_in &&
            ((next_s.on_cnt >= CNT_W'(MATCH_MIN) && next_s.off_cnt >= CNT_W'(MATCH_MIN)) ||
             (next_s.on_alt >= 2'(ALT_MIN) && next_s.off_alt >= 2'(ALT_MIN)));
    end

    // state register
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign flag_out = s.flag;
endmodule

// File: hdl/hbpd_top.sv
// Function
// - pins one/two decode high/low gates of bridge one
// - pins three/four decode bridge two, both high off
// - pins five/six decode bridge three, both high off
// - freewheel low side off before high side on
// - late edge in timeout gives hard turn-off
// - high-side edge withheld until freewheel blank ends
// - low-side edge withheld until active blank ends
// - detection off, high-side select means high active
// - detection on, detected high side is active
// - active high side off before low side on
// - regulation flag per bridge, adaptive scheme only
// - regulated when match or alternation condition holds
// - match needs both delay counters at least eight
// - turn-on counter up on match, else down
// - turn-off counter up on match, else down
// - three consecutive sign changes of both errors mean regulated
// - gate current code has sixty-four steps
// - charge and precharge codes share one encoding
// - six-input mode needs count select and enable
// - select 00 passive off, 11 active off
// - short pulses keep the opposite transistor off
//
// The strobed register port and the register offsets were left to the implementer.
module hbpd_top (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [5:0] pwm_in,
    input wire logic [2:0] active_hs_detected_in,
    input wire logic [2:0] measure_strobe_in,
    input wire logic [2:0][hbpd_pkg::DLY_W-1:0] measured_turnon_delay_in,
    input wire logic [2:0][hbpd_pkg::DLY_W-1:0] measured_turnoff_delay_in,
    input wire hbpd_pkg::hbpd_bus_t bus_in,
    output logic [hbpd_pkg::DATA_W-1:0] rdata_out,
    output hbpd_pkg::hbpd_gate_t [2:0] gates_out,
    output logic [2:0][hbpd_pkg::CODE_W-1:0] charge_current_code_out,
    output logic [2:0][hbpd_pkg::CODE_W-1:0] initial_precharge_code_out,
    output logic [2:0] delay_regulated_flag_out
);
    import hbpd_pkg::*;

    // all state of the block
    typedef struct packed {
        logic [5:0] sync1;                   // first synchroniser stage
        logic [5:0] sync2;                   // second stage, decode input
        logic [DATA_W-1:0] ctrl;             // mode and enables
        logic [NUM_HB*DLY_W-1:0] ton;        // target turn-on delays
        logic [NUM_HB*DLY_W-1:0] toff;       // target turn-off delays
        logic [NUM_HB*CODE_W-1:0] chg;       // charge current codes
        logic [NUM_HB*CODE_W-1:0] pchg;      // initial precharge codes
        logic [DATA_W-1:0] rdata;            // read answer
        hbpd_seq_t [2:0] seq;                // sequencer per bridge
        logic [2:0][TMR_W-1:0] tmr;          // cycles since gates went off
        hbpd_gate_t [2:0] gate;              // registered gate commands
    } hbpd_top_t;
    hbpd_top_t s, next_s;

    logic [2:0] reg_flag;  // regulation flags from the trackers
    logic cnt_sel;         // six-input mode selected
    logic det_en;          // active/freewheel detection on
    logic [1:0] scheme;    // gate control scheme
    logic seqd;            // break-before-make sequencing active
    logic adaptive;        // adaptive scheme, 10 or 11

    // control fields
    assign cnt_sel = s.ctrl[CNT_SEL_BIT];
    assign det_en = s.ctrl[DET_EN_BIT];
    assign scheme = s.ctrl[SCHEME_LSB +: 2];
    // sequencing needs scheme 01/10 and postcharge enabled
    assign seqd = (scheme == 2'h1 || scheme == 2'h2) && !s.ctrl[POST_DIS_BIT];
    assign adaptive = scheme[1];

    // next-state logic for bus, synchroniser and sequencers
    always_comb begin
        logic [1:0] drv;
        logic en;
        logic want_hs;
        logic want_ls;
        logic act_hs;
        logic [TMR_W-1:0] blank_hs;
        logic [TMR_W-1:0] blank_ls;
        drv = 2'h0;
        en = 1'b0;
        want_hs = 1'b0;
        want_ls = 1'b0;
        act_hs = 1'b0;
        blank_hs = '0;
        blank_ls = '0;
        next_s = s;
        // two-stage synchroniser, only stage two is decoded
        next_s.sync1 = pwm_in;
        next_s.sync2 = s.sync1;

        // register writes
        if (bus_in.wr) begin
            case (bus_in.addr)
                REG_CTRL: next_s.ctrl = bus_in.wdata;
                REG_TON: next_s.ton = bus_in.wdata[NUM_HB*DLY_W-1:0];
                REG_TOFF: next_s.toff = bus_in.wdata[NUM_HB*DLY_W-1:0];
                REG_CHG: next_s.chg = bus_in.wdata[NUM_HB*CODE_W-1:0];
                REG_PCHG: next_s.pchg = bus_in.wdata[NUM_HB*CODE_W-1:0];
                default: next_s.ctrl = s.ctrl;  // status and holes ignore writes
            endcase
        end
        // read answer stands for one cycle only
        next_s.rdata = '0;
        if (bus_in.rd) begin
            case (bus_in.addr)
                REG_CTRL: next_s.rdata = s.ctrl;
                REG_TON: next_s.rdata = DATA_W'(s.ton);
                REG_TOFF: next_s.rdata = DATA_W'(s.toff);
                REG_CHG: next_s.rdata = DATA_W'(s.chg);
                REG_PCHG: next_s.rdata = DATA_W'(s.pchg);
                // regulation flags readable with gate state
                REG_STATUS: begin
                    next_s.rdata = DATA_W'({s.gate[2].ls, s.gate[1].ls, s.gate[0].ls,
                                            s.gate[2].hs, s.gate[1].hs, s.gate[0].hs, reg_flag});
                end
                default: next_s.rdata = '0;  // unmapped reads as zero
            endcase
        end

        // one sequencer per half-bridge
        for (int i = 0; i < NUM_HB; i++) begin
            drv = s.ctrl[DRIVE_LSB + 2*i +: 2];
            // six-input operation needs count select and enable
            en = cnt_sel && s.ctrl[PWM_EN_LSB + i] && (drv == DRV_LS_PWM || drv == DRV_HS_PWM);
            // decode pair, both high means both off
            want_hs = en && s.sync2[2*i] && !s.sync2[2*i+1];
            want_ls = en && s.sync2[2*i+1] && !s.sync2[2*i];
            // choose which side is the active transistor
            act_hs = det_en ? active_hs_detected_in[i] : (drv == DRV_HS_PWM);
            // active turn-on waits freewheel blank, else active blank
            blank_hs = act_hs ? TMR_W'(FW_BLANK_CYC) : TMR_W'(ACT_BLANK_CYC);
            blank_ls = act_hs ? TMR_W'(ACT_BLANK_CYC) : TMR_W'(FW_BLANK_CYC);
            if (s.tmr[i] != '1) begin
                next_s.tmr[i] = s.tmr[i] + 1'b1;
            end
            next_s.gate[i].hard_off = 1'b0;
            case (s.seq[i])
                SEQ_OFF: begin
                    // freewheel side is already off in this state
                    if (want_hs && (!seqd || s.tmr[i] >= blank_hs)) begin
                        next_s.seq[i] = SEQ_HS;
                        // active edge inside the timeout discharges hard
                        next_s.gate[i].hard_off = seqd && act_hs && s.tmr[i] < TMR_W'(FW_TIMEOUT_CYC);
                    // active side was turned off before this
                    end else if (want_ls && (!seqd || s.tmr[i] >= blank_ls)) begin
                        next_s.seq[i] = SEQ_LS;
                        next_s.gate[i].hard_off = seqd && !act_hs && s.tmr[i] < TMR_W'(FW_TIMEOUT_CYC);
                    end
                end
                SEQ_HS: begin
                    // any other request only turns this gate off
                    if (!want_hs) begin
                        next_s.seq[i] = SEQ_OFF;
                        next_s.tmr[i] = '0;
                    end
                end
                SEQ_LS: begin
                    if (!want_ls) begin
                        next_s.seq[i] = SEQ_OFF;
                        next_s.tmr[i] = '0;
                    end
                end
                default: begin
                    next_s.seq[i] = SEQ_OFF;
                    next_s.tmr[i] = '0;
                end
            endcase
            // gates follow the sequencer; never both on at once
            next_s.gate[i].hs = (next_s.seq[i] == SEQ_HS);
            next_s.gate[i].ls = (next_s.seq[i] == SEQ_LS);
            // select 11 holds both off actively, 00 leaves it passive
            next_s.gate[i].hold_off = cnt_sel && (drv == DRV_ACTIVE_OFF);
        end
    end

    // state register
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '{sync1: '0, sync2: '0, ctrl: CTRL_RST, ton: DLY_RST, toff: DLY_RST,
                   chg: CODE_RST, pchg: CODE_RST, rdata: '0, seq: '{SEQ_OFF, SEQ_OFF, SEQ_OFF},
                   tmr: '0, gate: '0};
        end else begin
            s <= next_s;
        end
    end

    // regulation trackers, one per bridge
    genvar g;
    generate
        for (g = 0; g < NUM_HB; g++) begin : g_trk
            hbpd_reg_track u_trk (
                .clock_in(clock_in),
                .reset_n_in(reset_n_in),
                .strobe_in(measure_strobe_in[g]),
                .adaptive_in(adaptive),
                .meas_on_in(measured_turnon_delay_in[g]),
                .meas_off_in(measured_turnoff_delay_in[g]),
                .tgt_on_in(s.ton[g*DLY_W +: DLY_W]),
                .tgt_off_in(s.toff[g*DLY_W +: DLY_W]),
                .flag_out(reg_flag[g])
            );
            // codes pass out unchanged, lowest code lowest current
            assign charge_current_code_out[g] = s.chg[g*CODE_W +: CODE_W];
            assign initial_precharge_code_out[g] = s.pchg[g*CODE_W +: CODE_W];
        end
    endgenerate

    // outputs straight from flops
    assign rdata_out = s.rdata;
    assign gates_out = s.gate;
    assign delay_regulated_flag_out = reg_flag;

    // checks on the block's own behaviour
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    generate
        for (g = 0; g < NUM_HB; g++) begin : g_chk
            a_pair_both_off: assert property (
                s.sync2[2*g +: 2] == 2'h3 |=> !gates_out[g].hs && !gates_out[g].ls)
                else $error("both inputs high but a gate is on");
            a_no_overlap: assert property (
                !(gates_out[g].hs && gates_out[g].ls))
                else $error("high and low gate on together");
            // the turn-on was decided one edge earlier, so the mode seen then counts
            a_hs_break_make: assert property (
                $rose(gates_out[g].hs) && $past(seqd) |-> $past(!gates_out[g].ls, 1) && $past(!gates_out[g].ls, 2))
                else $error("high side on without low side off first");
            // active high side must be off before the freewheel side comes on
            a_ls_break_make: assert property (
                $rose(gates_out[g].ls) && $past(seqd) |-> $past(!gates_out[g].hs, 1) && $past(!gates_out[g].hs, 2))
                else $error("low side on before high side was off");
            a_hs_blank_wait: assert property (
                $rose(gates_out[g].hs) && $past(seqd) |-> $past(s.tmr[g]) >= TMR_W'(ACT_BLANK_CYC) ||
                $past(s.tmr[g]) >= TMR_W'(FW_BLANK_CYC))
                else $error("high side on inside blanking");
            a_ls_blank_wait: assert property (
                $rose(gates_out[g].ls) && $past(seqd) && $past(s.tmr[g]) < TMR_W'(FW_BLANK_CYC) &&
                $past(s.tmr[g]) < TMR_W'(ACT_BLANK_CYC) |-> 1'b0)
                else $error("low side on inside blanking");
            a_sel_passive_off: assert property (
                s.ctrl[DRIVE_LSB + 2*g +: 2] == DRV_PASSIVE_OFF ##1
                s.ctrl[DRIVE_LSB + 2*g +: 2] == DRV_PASSIVE_OFF |=>
                !gates_out[g].hs && !gates_out[g].ls && !gates_out[g].hold_off)
                else $error("passive off select left a gate driven");
            a_mode_gates_off: assert property (
                !cnt_sel [*2] |=> !gates_out[g].hs && !gates_out[g].ls)
                else $error("gate on outside six-input mode");
            a_hard_off_time: assert property (
                gates_out[g].hard_off |-> gates_out[g].hs || gates_out[g].ls)
                else $error("hard turn-off without turn-on");
            // hard discharge only while the freewheel off timeout still runs
            a_hard_off_window: assert property (
                gates_out[g].hard_off |-> $past(s.tmr[g]) < TMR_W'(FW_TIMEOUT_CYC))
                else $error("hard turn-off after the timeout");
            // select 11 in six-input mode holds both gates actively off
            a_hold_off_sel: assert property (
                cnt_sel && s.ctrl[DRIVE_LSB + 2*g +: 2] == DRV_ACTIVE_OFF |=> gates_out[g].hold_off)
                else $error("active off select without hold");
            a_flag_adaptive: assert property (
                !adaptive [*2] |-> !delay_regulated_flag_out[g])
                else $error("regulation flag outside adaptive scheme");
        end
    endgenerate

    a_read_one_cycle: assert property (
        !bus_in.rd |=> rdata_out == '0)
        else $error("read data outside answer cycle");

    // main scenarios: swap, hard discharge, regulation, status read, active off
    c_hs_on: cover property (gates_out[0].hs ##[1:300] gates_out[0].ls);
    c_hard_off: cover property (gates_out[0].hard_off);
    c_hold_off: cover property (gates_out[2].hold_off);
    c_regulated: cover property ($rose(delay_regulated_flag_out[2]));
    c_status_read: cover property (bus_in.rd && bus_in.addr == REG_STATUS);
endmodule

// File: verification/hbpd_pwm_master.sv
// controller side: six pwm outputs, one per gate
module hbpd_pwm_master (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [5:0] pattern_in,  // wanted output levels
    output logic [5:0] pwm_out          // pwm lines toward the device
);
    timeunit 1ns;
    timeprecision 1ps;
    // outputs change just after an edge, like a timer peripheral
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwm_out <= 6'h00;  // lines parked low while held in reset
        end else begin
            pwm_out <= pattern_in;
        end
    end
endmodule

// File: verification/hbpd_top_tb.sv
module hbpd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hbpd_pkg::*;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [5:0] pattern = 6'h00;  // request to the controller model
    logic [5:0] pwm;
    logic [2:0] det = 3'h0;  // detection says high side active
    logic [2:0] strobe = 3'h0;
    logic [2:0][5:0] mon = '0;  // measured turn-on delays
    logic [2:0][5:0] moff = '0;  // measured turn-off delays
    hbpd_bus_t bus = '0;
    logic [31:0] rdata;
    hbpd_gate_t [2:0] gates;
    logic [2:0][5:0] chg;
    logic [2:0][5:0] pchg;
    logic [2:0] flag;
    int errors = 0;
    int num_checks = 0;
    // 100 MHz clock
    always #5 clock_in = ~clock_in;
    hbpd_pwm_master PART (.clock_in(clock_in), .reset_n_in(reset_n_in), .pattern_in(pattern), .pwm_out(pwm));
    hbpd_top DUT (.clock_in(clock_in), .reset_n_in(reset_n_in), .pwm_in(pwm), .active_hs_detected_in(det),
        .measure_strobe_in(strobe), .measured_turnon_delay_in(mon), .measured_turnoff_delay_in(moff),
        .bus_in(bus), .rdata_out(rdata), .gates_out(gates), .charge_current_code_out(chg),
        .initial_precharge_code_out(pchg), .delay_regulated_flag_out(flag));
    // verdict, reached from the main sequence or the watchdog
    task automatic stop_test();
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // n edges, then let that edge's updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clock_in);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_in);
        bus <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clock_in);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock_in);
        bus <= '0;
        #1 d = rdata;
    endtask
    // one measurement pulse on the masked bridges
    task automatic strb(input logic [2:0] m, input logic [5:0] on, input logic [5:0] off);
        @(posedge clock_in);
        strobe <= m;
        mon <= {3{on}};
        moff <= {3{off}};
        @(posedge clock_in);
        strobe <= 3'h0;
        #1;
    endtask
    // gate pairs as {hs, ls} per bridge, bridge 0 lowest
    function automatic logic [5:0] hl_now();
        logic [5:0] v;
        for (int i = 0; i < 3; i++) begin
            v[2*i+1] = gates[i].hs;
            v[2*i] = gates[i].ls;
        end
        return v;
    endfunction
    function automatic logic [5:0] hl_exp(input logic [5:0] p);
        logic [5:0] e;
        for (int i = 0; i < 3; i++) begin
            e[2*i+1] = p[2*i] & ~p[2*i+1];
            e[2*i] = p[2*i+1] & ~p[2*i];
        end
        return e;
    endfunction
    // control reset value, codes at both ends of the range, refused places
    task automatic t_regs();
        logic [31:0] d;
        bus_rd(REG_CTRL, d);
        chk(d, 32'h0);
        bus_wr(REG_CHG, 32'h0002A03F);
        bus_wr(REG_PCHG, 32'h00001FC0);
        bus_wr(REG_STATUS, 32'hFFFFFFFF);
        tick(1);
        chk(32'(chg), 32'(18'h2A03F));
        chk(32'(pchg), 32'(18'h01FC0));
        bus_rd(REG_CHG, d);
        chk(d, 32'h0002A03F);
        bus_rd(REG_STATUS, d);
        chk(d, 32'h0);
        bus_rd(3'h6, d);
        chk(d, 32'h0);
        tick(1);
        chk(rdata, 32'h0);
    endtask
    // every input pattern, both pwm drive selects, direct decode
    task automatic t_decode();
        for (int s = 0; s < 2; s++) begin
            bus_wr(REG_CTRL, (s == 0) ? 32'h000015E1 : 32'h00002AE1);
            for (int p = 0; p < 64; p++) begin
                @(posedge clock_in);
                pattern <= 6'(p);
                tick(6);
                chk(32'(hl_now()), 32'(hl_exp(6'(p))));
            end
        end
    endtask
    // modes that must keep every gate off whatever the inputs say
    task automatic t_off_modes();
        logic [31:0] c [4] = '{32'h000000E1, 32'h00003FE1, 32'h00001501, 32'h000015E0};
        for (int k = 0; k < 4; k++) begin
            // requests that would turn gates on in an enabled mode
            @(posedge clock_in);
            pattern <= k[0] ? 6'h2A : 6'h15;
            bus_wr(REG_CTRL, c[k]);
            tick(6);
            chk(32'(hl_now()), 32'h0);
            chk(32'({gates[2].hold_off, gates[1].hold_off, gates[0].hold_off}), (k == 1) ? 32'h7 : 32'h0);
        end
    endtask
    // bridge 0 high side active, freewheel low side swapped in and out
    task automatic t_sequence();
        int n;
        bus_wr(REG_CTRL, 32'h00000225);
        @(posedge clock_in);
        pattern <= 6'h02;
        tick(120);
        chk(32'(hl_now()), 32'h1);
        @(posedge clock_in);
        pattern <= 6'h01;
        n = 0;
        while (gates[0].hs !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        // input flop, two sync stages, the off edge, then blank plus one
        chk(32'(n), 32'(FW_BLANK_CYC + 5));
        chk(32'({gates[0].ls, gates[0].hard_off}), 32'h1);
        @(posedge clock_in);
        pattern <= 6'h02;
        n = 0;
        while (gates[0].ls !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(32'(n), 32'(ACT_BLANK_CYC + 5));
        chk(32'(gates[0].hs), 32'h0);
        // detection on names the high side even with low-side select
        bus_wr(REG_CTRL, 32'h00000127);
        det <= 3'h1;
        @(posedge clock_in);
        pattern <= 6'h01;
        tick(8);
        chk(32'(gates[0].hs), 32'h0);
        n = 8;
        while (gates[0].hs !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(32'(n), 32'(FW_BLANK_CYC + 5));
        // a high side taken as active brings the hard discharge on its turn-on
        chk(32'(gates[0].hard_off), 32'h1);
        @(posedge clock_in);
        pattern <= 6'h00;
        det <= 3'h0;
    endtask
    // delay counters and the regulation flag under the adaptive scheme
    task automatic t_regulation();
        logic [31:0] d;
        bus_wr(REG_CTRL, 32'h00000009);
        bus_wr(REG_TON, 32'h00005145);
        bus_wr(REG_TOFF, 32'h00005145);
        repeat (7) strb(3'h5, 6'h05, 6'h05);
        chk(32'(flag), 32'h0);
        strb(3'h5, 6'h05, 6'h05);
        chk(32'(flag), 32'h5);
        strb(3'h1, 6'h06, 6'h05);
        strb(3'h4, 6'h05, 6'h06);
        chk(32'(flag), 32'h0);
        strb(3'h2, 6'h07, 6'h07);
        strb(3'h2, 6'h03, 6'h03);
        strb(3'h2, 6'h07, 6'h07);
        strb(3'h2, 6'h03, 6'h03);
        chk(32'(flag), 32'h2);
        bus_rd(REG_STATUS, d);
        chk(d, 32'h2);
        bus_wr(REG_CTRL, 32'h00000005);
        tick(2);
        chk(32'(flag), 32'h0);
    endtask
    // watchdog, well beyond the 1300 or so cycles the tests need
    initial begin
        #200us;
        errors++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clock_in);
        reset_n_in <= 1'b1;
        tick(2);
        chk(32'(hl_now()), 32'h0);
        t_regs();
        t_decode();
        t_off_modes();
        t_sequence();
        t_regulation();
        stop_test();
    end
endmodule
